// File: test/cascaded_period_capture_timer_tb_top.sv
// Self-checking bench of the cascaded period capture timer
`timescale 1ns/1ps
module cascaded_period_capture_timer_tb_top;
    localparam int PERIOD = 60;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, lfsr = 32'h95eb0b3c;
    logic [31:0] frz;
    int exp_lo_q[$];
    logic [31:0] prdata;
    logic pready, pslverr, irq, er, fu = 0, fl = 0, up_pin, lo_pin;
    int errors = 0, num_checks = 0;
    cascaded_period_capture_timer u_cascaded_period_capture_timer
    (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .upper_capture_pin(up_pin), .lower_capture_pin(lo_pin), .irq(irq)
    );
    pulse_source u_pulse_source
    (
        .pclk(pclk), .fire_upper(fu), .fire_lower(fl),
        .upper_pin(up_pin), .lower_pin(lo_pin)
    );
    // ****************************************
    // Helpers
    // ****************************************
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task rchk(input logic [15:0] idx, input logic [31:0] exp, input string nm);
        apb(0, idx, 32'h0);
        check(nm, exp, rd);
    endtask : rchk
    task fire;
        @(posedge pclk);
        fu <= 1;
        fl <= 1;
        @(posedge pclk);
        fu <= 0;
        fl <= 0;
    endtask : fire
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rchk(cascade_timer_pkg::IDX_UPPER_CC, 32'h0000ffff, "cc_reset");
        rchk(cascade_timer_pkg::IDX_STATUS, 32'h0, "status_reset");
        repeat (3)
        begin
            lfsr = lfsr_next(lfsr);
            apb(1, cascade_timer_pkg::IDX_UPPER_CC, {16'h0, lfsr[15:0]});
            rchk(cascade_timer_pkg::IDX_UPPER_CC, {16'h0, lfsr[15:0]}, "cc");
        end
        apb(1, 16'h0123, 32'h5a5a);
        check("unmapped_err", 32'h1, {31'h0, er});
        apb(0, 16'h0123, 32'h0);
        check("unmapped_rd", 32'h0, rd);
        apb(1, cascade_timer_pkg::IDX_LOWER_CTRL, 32'h1);
        apb(1, cascade_timer_pkg::IDX_LOWER_CNT, 32'hfff0);
        rchk(cascade_timer_pkg::IDX_LOWER_CNT, 32'hfff0, "lo_cnt");
        apb(1, cascade_timer_pkg::IDX_UPPER_CNT, 32'hffff);
        apb(1, cascade_timer_pkg::IDX_UPPER_CTRL, 32'h807);
        apb(1, cascade_timer_pkg::IDX_LOWER_PINF, 32'h8);
        apb(1, cascade_timer_pkg::IDX_LOWER_MODE, 32'h0);
        apb(1, cascade_timer_pkg::IDX_LOWER_CTRL, 32'h20);
        repeat (30) @(posedge pclk);
        fire();
        // Clear on capture leaves the count one short of the spacing
        exp_lo_q.push_back(PERIOD - 1);
        fork
            begin
                repeat (PERIOD - 2) @(posedge pclk);
                fire();
            end
        join_none
        repeat (8) @(posedge pclk);
        rchk(cascade_timer_pkg::IDX_UPPER_CC, 32'h0, "hi_cap");
        rchk(cascade_timer_pkg::IDX_STATUS, 32'h33, "status");
        apb(1, cascade_timer_pkg::IDX_IRQ_MASK, 32'h10);
        @(posedge pclk);
        #1 check("irq_on", 32'h1, {31'h0, irq});
        apb(1, cascade_timer_pkg::IDX_STATUS, 32'h0);
        rchk(cascade_timer_pkg::IDX_STATUS, 32'h0, "status_clr");
        #1 check("irq_off", 32'h0, {31'h0, irq});
        repeat (PERIOD) @(posedge pclk);
        apb(0, cascade_timer_pkg::IDX_LOWER_CC, 32'h0);
        check("lo_cap", exp_lo_q.pop_front(), rd);
        // Clock enable low for ten edges holds the running counter
        apb(0, cascade_timer_pkg::IDX_LOWER_CNT, 32'h0);
        frz = rd;
        @(posedge pclk);
        ce <= 0;
        repeat (10) @(posedge pclk);
        ce <= 1;
        apb(0, cascade_timer_pkg::IDX_LOWER_CNT, 32'h0);
        check("freeze", 32'h4, (rd - frz) & 32'hffff);
        rchk(cascade_timer_pkg::IDX_UPPER_CC, 32'h0, "hi_cap2");
        rchk(cascade_timer_pkg::IDX_STATUS, 32'h3, "status2");
        tally_and_finish();
    end
endmodule : cascaded_period_capture_timer_tb_top

// File: test/pulse_source.sv
// Pulse source model driving both capture pins
`timescale 1ns/1ps
module pulse_source
(
    input wire logic pclk,
    input wire logic fire_upper,
    input wire logic fire_lower,
    output logic upper_pin,
    output logic lower_pin
);
    int hold_upper = 0;
    int hold_lower = 0;
    // ****************************************
    // Each request gives a four-cycle high pulse
    // ****************************************
    always @(posedge pclk)
    begin
        hold_upper <= fire_upper ? 4 : (hold_upper > 0 ? hold_upper - 1 : 0);
        hold_lower <= fire_lower ? 4 : (hold_lower > 0 ? hold_lower - 1 : 0);
    end
    assign upper_pin = hold_upper > 0;
    assign lower_pin = hold_lower > 0;
endmodule : pulse_source

// File: verilog/cascade_timer_pkg.sv
// Register map, field layout and reset values of the cascaded capture timer
package cascade_timer_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;

    // ************************************************************
    // Register indices, byte address is four times the index
    // ************************************************************
    localparam logic [15:0] IDX_UPPER_CTRL = 16'hf040;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hf044;
    localparam logic [15:0] IDX_STATUS = 16'hf045;
    localparam logic [15:0] IDX_UPPER_CNT = 16'hf046;
    localparam logic [15:0] IDX_UPPER_CC = 16'hf048;
    localparam logic [15:0] IDX_LOWER_CTRL = 16'hf050;
    localparam logic [15:0] IDX_LOWER_MODE = 16'hf051;
    localparam logic [15:0] IDX_LOWER_PINF = 16'hf052;
    localparam logic [15:0] IDX_LOWER_CNT = 16'hf056;
    localparam logic [15:0] IDX_LOWER_CC = 16'hf058;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CCLR_LSB = 5;
    localparam int CKEG_LSB = 3;
    localparam int TPSC_LSB = 0;
    localparam int MD_LSB = 0;
    localparam int PINF_LSB = 0;
    localparam int UPPER_PS_LSB = 0;
    localparam int UPPER_PINF_LSB = 8;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [1:0] CCLR_BY_CAPTURE = 2'h1;
    localparam logic [1:0] CKEG_RISING = 2'h0;
    localparam logic [2:0] TPSC_INTERNAL = 3'h0;
    localparam logic [2:0] TPSC_CASCADE = 3'h7;
    localparam logic [1:0] MD_NORMAL = 2'h0;

    // ************************************************************
    // Status and mask bit positions
    // ************************************************************
    localparam int STAT_W = 6;
    localparam int ST_CAP_HI = 0;
    localparam int ST_CAP_LO = 1;
    localparam int ST_OVF_HI = 4;
    localparam int ST_OVF_LO = 5;

    // ************************************************************
    // Reset values and counter maximum
    // ************************************************************
    localparam logic [15:0] CC_RST = 16'hffff;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] LOWER_CTRL_RST = 8'h00;
    localparam logic [7:0] LOWER_MODE_RST = 8'h00;
    localparam logic [7:0] LOWER_PINF_RST = 8'h00;
    localparam logic [2:0] UPPER_PS_RST = 3'h0;
    localparam logic [3:0] UPPER_PINF_RST = 4'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 6'h00;

endpackage : cascade_timer_pkg

// File: verilog/cascaded_period_capture_timer.sv
// Cascaded 32-bit period capture timer with APB register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module cascaded_period_capture_timer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cascade_timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [cascade_timer_pkg::DATA_W-1:0] pwdata,
    output logic [cascade_timer_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic upper_capture_pin,
    input wire logic lower_capture_pin,
    output logic irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] upper_capture_compare;
        logic [15:0] lower_capture_compare;
        logic [15:0] upper_counter;
        logic [15:0] lower_counter;
        logic [7:0] lower_timer_control;
        logic [7:0] lower_timer_mode;
        logic [7:0] lower_pin_function_control;
        logic [2:0] upper_prescale;
        logic [3:0] upper_pin_function;
        logic [cascade_timer_pkg::STAT_W-1:0] status;
        logic [cascade_timer_pkg::STAT_W-1:0] armed;
        logic [cascade_timer_pkg::STAT_W-1:0] mask;
        logic [cascade_timer_pkg::DATA_W-1:0] rdata;
    } timer_s;

    timer_s st_ff;
    timer_s nxt_st;

    logic upper_rise;
    logic lower_rise;
    logic wr_acc;
    logic rd_acc;
    logic setup;
    logic hit;
    logic [cascade_timer_pkg::DATA_W-1:0] rd_val;
    logic we_upper_ctrl;
    logic we_mask;
    logic we_status;
    logic rd_status;
    logic we_upper_cnt;
    logic we_upper_cc;
    logic we_lower_ctrl;
    logic we_lower_mode;
    logic we_lower_pinf;
    logic we_lower_cnt;
    logic we_lower_cc;
    logic count_en;
    logic lo_wrap;
    logic hi_inc;
    logic hi_wrap;
    logic cap_hi;
    logic cap_lo;
    logic lo_clear;
    logic [cascade_timer_pkg::STAT_W-1:0] st_set;
    logic [cascade_timer_pkg::STAT_W-1:0] st_clr;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [cascade_timer_pkg::ADDR_W-1:0] byte_addr
    (
        input logic [15:0] idx
    );
        byte_addr = {idx, 2'h0};
    endfunction : byte_addr

    // Pin field 1x00 selects rising-edge input capture
    function automatic logic is_capture(input logic [3:0] pinf);
        is_capture = pinf[3] & ~pinf[1] & ~pinf[0];
    endfunction : is_capture

    // ************************************************************
    // Capture pin synchronisers
    // ************************************************************
    pin_rise_sync u_upper_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin(upper_capture_pin),
        .rise(upper_rise)
    );

    pin_rise_sync u_lower_sync
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .pin(lower_capture_pin),
        .rise(lower_rise)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    always_comb
    begin
        hit = 1'b1;
        rd_val = '0;
        if (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CTRL))
        begin
            rd_val[cascade_timer_pkg::UPPER_PS_LSB +: 3] = st_ff.upper_prescale;
            rd_val[cascade_timer_pkg::UPPER_PINF_LSB +: 4] =
                st_ff.upper_pin_function;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_IRQ_MASK))
        begin
            rd_val[cascade_timer_pkg::STAT_W-1:0] = st_ff.mask;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_STATUS))
        begin
            rd_val[cascade_timer_pkg::STAT_W-1:0] = st_ff.status;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CNT))
        begin
            rd_val[15:0] = st_ff.upper_counter;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CC))
        begin
            rd_val[15:0] = st_ff.upper_capture_compare;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CTRL))
        begin
            rd_val[7:0] = st_ff.lower_timer_control;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_MODE))
        begin
            rd_val[7:0] = st_ff.lower_timer_mode;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_PINF))
        begin
            rd_val[7:0] = st_ff.lower_pin_function_control;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CNT))
        begin
            rd_val[15:0] = st_ff.lower_counter;
        end
        else if (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CC))
        begin
            rd_val[15:0] = st_ff.lower_capture_compare;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    assign we_upper_ctrl = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CTRL));
    assign we_mask = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_IRQ_MASK));
    assign we_status = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_STATUS));
    assign rd_status = rd_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_STATUS));
    assign we_upper_cnt = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CNT));
    assign we_upper_cc = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_UPPER_CC));
    assign we_lower_ctrl = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CTRL));
    assign we_lower_mode = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_MODE));
    assign we_lower_pinf = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_PINF));
    assign we_lower_cnt = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CNT));
    assign we_lower_cc = wr_acc &
        (paddr == byte_addr(cascade_timer_pkg::IDX_LOWER_CC));

    // ************************************************************
    // Counting and capture events
    // ************************************************************
    assign count_en =
        (st_ff.lower_timer_control[cascade_timer_pkg::TPSC_LSB +: 3] ==
         cascade_timer_pkg::TPSC_INTERNAL) &&
        (st_ff.lower_timer_control[cascade_timer_pkg::CKEG_LSB +: 2] ==
         cascade_timer_pkg::CKEG_RISING) &&
        (st_ff.lower_timer_mode[cascade_timer_pkg::MD_LSB +: 2] ==
         cascade_timer_pkg::MD_NORMAL);
    assign lo_wrap = count_en &
        (st_ff.lower_counter == cascade_timer_pkg::CNT_MAX);
    assign hi_inc = lo_wrap &
        (st_ff.upper_prescale == cascade_timer_pkg::TPSC_CASCADE);
    assign hi_wrap = hi_inc &
        (st_ff.upper_counter == cascade_timer_pkg::CNT_MAX);
    assign cap_hi = upper_rise & is_capture(st_ff.upper_pin_function);
    assign cap_lo = lower_rise & is_capture(
        st_ff.lower_pin_function_control[cascade_timer_pkg::PINF_LSB +: 4]
    );
    assign lo_clear = cap_lo &
        (st_ff.lower_timer_control[cascade_timer_pkg::CCLR_LSB +: 2] ==
         cascade_timer_pkg::CCLR_BY_CAPTURE);

    always_comb
    begin
        st_set = '0;
        st_set[cascade_timer_pkg::ST_CAP_HI] = cap_hi;
        st_set[cascade_timer_pkg::ST_CAP_LO] = cap_lo;
        st_set[cascade_timer_pkg::ST_OVF_HI] = hi_wrap;
        st_set[cascade_timer_pkg::ST_OVF_LO] = lo_wrap;
    end

    // Only bits read as one and then written zero clear
    assign st_clr = we_status ?
        (st_ff.armed & ~pwdata[cascade_timer_pkg::STAT_W-1:0]) : '0;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        nxt_st = st_ff;
        if (setup)
        begin
            nxt_st.rdata = rd_val;
        end
        if (we_upper_ctrl)
        begin
            nxt_st.upper_prescale =
                pwdata[cascade_timer_pkg::UPPER_PS_LSB +: 3];
            nxt_st.upper_pin_function =
                pwdata[cascade_timer_pkg::UPPER_PINF_LSB +: 4];
        end
        if (we_mask)
        begin
            nxt_st.mask = pwdata[cascade_timer_pkg::STAT_W-1:0];
        end
        if (we_lower_ctrl)
        begin
            nxt_st.lower_timer_control = pwdata[7:0];
        end
        if (we_lower_mode)
        begin
            nxt_st.lower_timer_mode = pwdata[7:0];
        end
        if (we_lower_pinf)
        begin
            nxt_st.lower_pin_function_control = pwdata[7:0];
        end
        // Capture clear beats software write beats counting
        if (lo_clear)
        begin
            nxt_st.lower_counter = cascade_timer_pkg::CNT_RST;
        end
        else if (we_lower_cnt)
        begin
            nxt_st.lower_counter = pwdata[15:0];
        end
        else if (count_en)
        begin
            nxt_st.lower_counter = st_ff.lower_counter + 16'h0001;
        end
        if (we_upper_cnt)
        begin
            nxt_st.upper_counter = pwdata[15:0];
        end
        else if (hi_inc)
        begin
            nxt_st.upper_counter = st_ff.upper_counter + 16'h0001;
        end
        // Both halves sample pre-update values in one cycle
        if (cap_hi)
        begin
            nxt_st.upper_capture_compare = st_ff.upper_counter;
        end
        else if (we_upper_cc)
        begin
            nxt_st.upper_capture_compare = pwdata[15:0];
        end
        if (cap_lo)
        begin
            nxt_st.lower_capture_compare = st_ff.lower_counter;
        end
        else if (we_lower_cc)
        begin
            nxt_st.lower_capture_compare = pwdata[15:0];
        end
        // Set wins over clear
        nxt_st.status = (st_ff.status & ~st_clr) | st_set;
        if (rd_status)
        begin
            nxt_st.armed = st_ff.rdata[cascade_timer_pkg::STAT_W-1:0] &
                st_ff.status;
        end
        else
        begin
            nxt_st.armed = st_ff.armed & ~st_clr;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff.upper_capture_compare <= cascade_timer_pkg::CC_RST;
            st_ff.lower_capture_compare <= cascade_timer_pkg::CC_RST;
            st_ff.upper_counter <= cascade_timer_pkg::CNT_RST;
            st_ff.lower_counter <= cascade_timer_pkg::CNT_RST;
            st_ff.lower_timer_control <= cascade_timer_pkg::LOWER_CTRL_RST;
            st_ff.lower_timer_mode <= cascade_timer_pkg::LOWER_MODE_RST;
            st_ff.lower_pin_function_control <=
                cascade_timer_pkg::LOWER_PINF_RST;
            st_ff.upper_prescale <= cascade_timer_pkg::UPPER_PS_RST;
            st_ff.upper_pin_function <= cascade_timer_pkg::UPPER_PINF_RST;
            st_ff.status <= cascade_timer_pkg::STAT_RST;
            st_ff.armed <= cascade_timer_pkg::STAT_RST;
            st_ff.mask <= cascade_timer_pkg::STAT_RST;
            st_ff.rdata <= '0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign irq = |(st_ff.status & st_ff.mask);

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_UPPER_CAPTURE: assert property (
        ce && cap_hi |=> st_ff.upper_capture_compare ==
            $past(st_ff.upper_counter))
        else $error("upper capture did not latch upper counter");
    AST_LOWER_CAPTURE: assert property (
        ce && cap_lo |=> st_ff.lower_capture_compare ==
            $past(st_ff.lower_counter))
        else $error("lower capture did not latch lower counter");
    AST_LOWER_CLEAR: assert property (
        ce && lo_clear |=> st_ff.lower_counter == 16'h0000)
        else $error("lower counter not cleared on capture");
    AST_LOWER_COUNT: assert property (
        ce && count_en && !lo_clear && !we_lower_cnt |=>
            st_ff.lower_counter == $past(st_ff.lower_counter) + 16'h0001)
        else $error("lower counter did not advance");
    AST_CASCADE_STEP: assert property (
        ce && lo_wrap && !we_upper_cnt &&
        st_ff.upper_prescale == 3'h7 |=>
            st_ff.upper_counter == $past(st_ff.upper_counter) + 16'h0001)
        else $error("upper counter missed lower overflow");
    AST_OVF_FLAG: assert property (
        ce && hi_inc && st_ff.upper_counter == 16'hffff |=>
            st_ff.status[cascade_timer_pkg::ST_OVF_HI] ##1
            (st_ff.status[cascade_timer_pkg::ST_OVF_HI] || $past(we_status)))
        else $error("upper overflow flag not set or lost");
    AST_COHERENT: assert property (
        ce && cap_hi && cap_lo |=>
            {st_ff.upper_capture_compare, st_ff.lower_capture_compare} ==
            $past({st_ff.upper_counter, st_ff.lower_counter}))
        else $error("32-bit snapshot halves not coherent");
    AST_NO_CAPTURE: assert property (
        ce && !cap_lo && !we_lower_cc |=> $stable(st_ff.lower_capture_compare))
        else $error("lower capture register changed without cause");
    AST_FREEZE: assert property (
        !ce |=> $stable(st_ff.lower_counter) && $stable(st_ff.upper_counter))
        else $error("counters moved while clock enable low");
    AST_IRQ_LEVEL: assert property (
        ce && (st_set & st_ff.mask) != '0 |=> irq)
        else $error("unmasked event did not raise interrupt");

    COV_CAPTURE_BOTH: cover property (ce && cap_hi && cap_lo);
    COV_CASCADE_WRAP: cover property (ce && hi_wrap);
    COV_CLEAR_FLAG: cover property (ce && st_clr != '0);

endmodule : cascaded_period_capture_timer

// File: verilog/pin_rise_sync.sv
// Two-stage synchroniser with rising-edge pulse for a capture pin
`timescale 1ns/1ps
module pin_rise_sync
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic pin,
    output logic rise
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sync_s;

    sync_s st_ff;
    sync_s nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.meta = pin;
        nxt_st.sync = st_ff.meta;
        nxt_st.last = st_ff.sync;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // One-cycle pulse, first stage stays out of it
    assign rise = st_ff.sync & ~st_ff.last;

endmodule : pin_rise_sync
